// ### logic/atipc_ahb_slave.v
// AHB-Lite slave front end: address phase capture and register strobes.
`default_nettype none
module atipc_ahb_slave (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   input  wire [7:0]  rd_data,
   output wire [7:0]  rd_idx,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   output wire        wr_stb,
   output reg  [7:0]  wr_idx,
   output wire [7:0]  wr_data
);
`include "atipc_consts.vh"
   wire       take;
   wire       inmap;
   reg        wr_pend_reg;

   // Word accesses inside the first kilobyte are decoded; others are ignored.
   assign inmap   = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
   assign take    = hsel && hready && (htrans == `ATIPC_HTRANS_NSEQ)
                    && (hsize == `ATIPC_HSIZE_WORD) && inmap;
   assign rd_idx  = haddr[9:2];
   assign wr_stb  = wr_pend_reg;
   assign wr_data = hwdata[7:0];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_idx      <= 8'h00;
         hrdata      <= 32'h00000000;
         hreadyout   <= 1'b0;
         hresp       <= 1'b0;
      end else begin
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         wr_pend_reg <= take && hwrite;
         if (take) begin
            wr_idx <= haddr[9:2];
         end
         if (take && !hwrite) begin
            hrdata <= {24'h000000, rd_data};
         end else if (hready) begin
            hrdata <= 32'h00000000;
         end
      end
   end
endmodule // atipc_ahb_slave
`default_nettype wire

// ### logic/atipc_consts.vh
// Constants of the alarm target and interrupt pin control block.
// Overview of operation
// [R1] Reserved bits 7..6 of the acquisition register and bits 7..6 and 3..2 of the pin register read zero and ignore writes.
// [R2] With the capture bit set, the next output sample is stored as the alarm targets.
// [R3] Software sets the capture bit at least once before relying on captured targets.
// [R4] One capture happens per fresh zero-to-one setting of the capture bit.
// [R5] The alarm-source bit picks programmed targets at zero and captured values at one.
// [R6] The four-bit exponent sets the acquisition interval to two to its power in seconds.
// [R7] Pin A polarity bit: zero gives active low, one gives active high.
// [R8] Pin A drive bit: zero gives push-pull, one gives open-drain.
// [R9] Pin B polarity bit: zero gives active low, one gives active high.
// [R10] Pin B drive bit: zero gives push-pull, one gives open-drain.
// [R11] An event flag reaches the router only while its enable bit is one.
// [R12] Enable bits 7..3 are data ready, FIFO, pressure window, temperature window, pressure threshold.
// [R13] Enable bits 2..0 are temperature threshold, pressure change, temperature change.
// [R14] A routing bit sends its enabled interrupt to pin B at zero and pin A at one.
// [R15] All enabled interrupts routed to one pin are ORed together.
// [R16] Each pin follows its polarity; open-drain drives only the active level.
`ifndef ATIPC_CONSTS_VH
`define ATIPC_CONSTS_VH
`define ATIPC_IDX_ACQ      8'h27
`define ATIPC_IDX_PINCFG   8'h28
`define ATIPC_IDX_IEN      8'h29
`define ATIPC_IDX_ROUTE    8'h2A
`define ATIPC_IDX_PTGT_HI  8'h30
`define ATIPC_IDX_PTGT_LO  8'h31
`define ATIPC_IDX_TTGT     8'h32
`define ATIPC_IDX_STATUS   8'h33
`define ATIPC_IDX_MASK     8'h34
`define ATIPC_RST_VAL      8'h00
`define ATIPC_ACQ_WMASK    8'h3F
`define ATIPC_PIN_WMASK    8'h33
`define ATIPC_ACQ_LOAD     5
`define ATIPC_ACQ_SEL      4
`define ATIPC_ACQ_EXP_MSB  3
`define ATIPC_ACQ_EXP_LSB  0
`define ATIPC_PIN_A_POL    5
`define ATIPC_PIN_A_OD     4
`define ATIPC_PIN_B_POL    1
`define ATIPC_PIN_B_OD     0
`define ATIPC_HSIZE_WORD   3'h2
`define ATIPC_HTRANS_NSEQ  2'h2
`define ATIPC_STEP_SEC     1
`define ATIPC_CLK_HZ       100000000
`endif

// ### logic/atipc_irq_pin.v
// Interrupt pin driver with polarity and push-pull or open-drain drive.
`default_nettype none
module atipc_irq_pin (
   input  wire hclk,
   input  wire hresetn,
   input  wire active,
   input  wire polarity,
   input  wire open_drain,
   output reg  pin_out,
   output reg  pin_oe
);
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out <= 1'b1;
         pin_oe  <= 1'b1;
      end else if (open_drain) begin
         // Open drain only pulls to the active level and otherwise lets go.
         pin_out <= polarity;
         pin_oe  <= active;
      end else begin
         pin_out <= polarity ? active : ~active;
         pin_oe  <= 1'b1;
      end
   end
endmodule // atipc_irq_pin
`default_nettype wire

// ### logic/atipc_top.v
// Alarm target selection, acquisition timer and interrupt pin control.
//
// The AHB-Lite slave port is this design's own decision.
`default_nettype none
`include "atipc_consts.vh"
module atipc_top #(
   parameter P_W            = 20,
   parameter T_W            = 12,
   parameter CYCLES_PER_SEC = `ATIPC_STEP_SEC * `ATIPC_CLK_HZ
) (
   input  wire           hclk,
   input  wire           hresetn,
   input  wire           hsel,
   input  wire [31:0]    haddr,
   input  wire [1:0]     htrans,
   input  wire           hwrite,
   input  wire [2:0]     hsize,
   input  wire           hready,
   input  wire [31:0]    hwdata,
   output wire [31:0]    hrdata,
   output wire           hreadyout,
   output wire           hresp,
   input  wire [7:0]     event_flags,
   input  wire           sample_valid,
   input  wire [P_W-1:0] sample_pressure,
   input  wire [T_W-1:0] sample_temperature,
   output reg  [P_W-1:0] alarm_pressure_target,
   output reg  [T_W-1:0] alarm_temperature_target,
   output reg  [3:0]     acquisition_period_exponent,
   output reg            acq_tick,
   output wire           irq_pin_a_out,
   output wire           irq_pin_a_oe,
   output wire           irq_pin_b_out,
   output wire           irq_pin_b_oe,
   output reg            irq
);
   reg  [7:0]     acq_reg;
   reg  [7:0]     pincfg_reg;
   reg  [7:0]     ien_reg;
   reg  [7:0]     route_reg;
   reg  [7:0]     ptgt_hi_reg;
   reg  [7:0]     ptgt_lo_reg;
   reg  [7:0]     ttgt_reg;
   reg  [7:0]     status_reg;
   reg  [7:0]     mask_reg;
   reg            arm_reg;
   reg  [P_W-1:0] cap_p_reg;
   reg  [T_W-1:0] cap_t_reg;
   reg  [31:0]    cyc_reg;
   reg  [15:0]    sec_reg;
   reg  [7:0]     rd_mux;
   reg  [7:0]     clr_mask;
   reg  [7:0]     acq_next;
   wire [7:0]     rd_idx;
   wire           wr_stb;
   wire [7:0]     wr_idx;
   wire [7:0]     wr_data;
   wire [7:0]     gated;
   wire [7:0]     to_a;
   wire [7:0]     to_b;
   wire           wr_acq;
   wire           sec_wrap;
   wire [15:0]    sec_last;

   atipc_ahb_slave u_bus (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hready    (hready),
      .hwdata    (hwdata),
      .rd_data   (rd_mux),
      .rd_idx    (rd_idx),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .wr_stb    (wr_stb),
      .wr_idx    (wr_idx),
      .wr_data   (wr_data)
   );

   always @* begin
      case (rd_idx)
         `ATIPC_IDX_ACQ:     rd_mux = acq_reg;
         `ATIPC_IDX_PINCFG:  rd_mux = pincfg_reg;
         `ATIPC_IDX_IEN:     rd_mux = ien_reg;
         `ATIPC_IDX_ROUTE:   rd_mux = route_reg;
         `ATIPC_IDX_PTGT_HI: rd_mux = ptgt_hi_reg;
         `ATIPC_IDX_PTGT_LO: rd_mux = ptgt_lo_reg;
         `ATIPC_IDX_TTGT:    rd_mux = ttgt_reg;
         `ATIPC_IDX_STATUS:  rd_mux = status_reg;
         `ATIPC_IDX_MASK:    rd_mux = mask_reg;
         default:            rd_mux = 8'h00;
      endcase
   end

   assign wr_acq = wr_stb && (wr_idx == `ATIPC_IDX_ACQ);

   always @* begin
      acq_next = wr_data & `ATIPC_ACQ_WMASK; // [R1]
      clr_mask = 8'h00;
      if (wr_stb && (wr_idx == `ATIPC_IDX_STATUS)) begin
         clr_mask = wr_data;
      end
   end

   assign gated = event_flags & ien_reg;      // [R11] [R12] [R13]
   assign to_a  = gated & route_reg;          // [R14]
   assign to_b  = gated & ~route_reg;         // [R14]

   // Control registers written by software.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acq_reg     <= `ATIPC_RST_VAL;
         pincfg_reg  <= `ATIPC_RST_VAL;
         ien_reg     <= `ATIPC_RST_VAL;
         route_reg   <= `ATIPC_RST_VAL;
         ptgt_hi_reg <= `ATIPC_RST_VAL;
         ptgt_lo_reg <= `ATIPC_RST_VAL;
         ttgt_reg    <= `ATIPC_RST_VAL;
         mask_reg    <= `ATIPC_RST_VAL;
      end else if (wr_stb) begin
         case (wr_idx)
            `ATIPC_IDX_ACQ:     acq_reg     <= acq_next;
            `ATIPC_IDX_PINCFG:  pincfg_reg  <= wr_data & `ATIPC_PIN_WMASK; // [R1]
            `ATIPC_IDX_IEN:     ien_reg     <= wr_data;
            `ATIPC_IDX_ROUTE:   route_reg   <= wr_data;
            `ATIPC_IDX_PTGT_HI: ptgt_hi_reg <= wr_data;
            `ATIPC_IDX_PTGT_LO: ptgt_lo_reg <= wr_data;
            `ATIPC_IDX_TTGT:    ttgt_reg    <= wr_data;
            `ATIPC_IDX_MASK:    mask_reg    <= wr_data;
            default:            ;
         endcase
      end
   end

   // Sticky status of enabled events; a new event wins over a clear.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg <= `ATIPC_RST_VAL;
         irq        <= 1'b0;
      end else begin
         status_reg <= (status_reg & ~clr_mask) | gated;
         irq        <= |(status_reg & mask_reg);
      end
   end

   // Target capture arms only on a fresh zero-to-one write of the capture bit.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         arm_reg   <= 1'b0;
         cap_p_reg <= {P_W{1'b0}};
         cap_t_reg <= {T_W{1'b0}};
      end else begin
         if (wr_acq && acq_next[`ATIPC_ACQ_LOAD] && !acq_reg[`ATIPC_ACQ_LOAD]) begin
            arm_reg <= 1'b1; // [R4]
         end else if (wr_acq && !acq_next[`ATIPC_ACQ_LOAD]) begin
            // Clearing the capture bit before a sample arrives cancels the pending load.
            arm_reg <= 1'b0; // [R2]
         end else if (sample_valid && arm_reg) begin
            arm_reg <= 1'b0; // [R4]
         end
         if (sample_valid && arm_reg) begin
            cap_p_reg <= sample_pressure;    // [R2]
            cap_t_reg <= sample_temperature; // [R2]
         end
      end
   end

   // Programmed targets sit in the top bits; the low bits are zero.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         alarm_pressure_target    <= {P_W{1'b0}};
         alarm_temperature_target <= {T_W{1'b0}};
      end else if (acq_reg[`ATIPC_ACQ_SEL]) begin
         alarm_pressure_target    <= cap_p_reg; // [R5]
         alarm_temperature_target <= cap_t_reg; // [R5]
      end else begin
         alarm_pressure_target    <= {ptgt_hi_reg, ptgt_lo_reg, {(P_W-16){1'b0}}}; // [R5]
         alarm_temperature_target <= {ttgt_reg, {(T_W-8){1'b0}}};                 // [R5]
      end
   end

   // Acquisition timer: a one-cycle tick every 2**exponent seconds.
   assign sec_wrap = (cyc_reg == CYCLES_PER_SEC - 1);
   assign sec_last = (16'h0001 << acq_reg[`ATIPC_ACQ_EXP_MSB:`ATIPC_ACQ_EXP_LSB]) - 16'h0001;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc_reg                     <= 32'h00000000;
         sec_reg                     <= 16'h0000;
         acq_tick                    <= 1'b0;
         acquisition_period_exponent <= 4'h0;
      end else begin
         acquisition_period_exponent <= acq_reg[`ATIPC_ACQ_EXP_MSB:`ATIPC_ACQ_EXP_LSB];
         acq_tick                    <= 1'b0;
         if (wr_acq) begin
            // Any write to the acquisition register restarts the interval.
            cyc_reg <= 32'h00000000;
            sec_reg <= 16'h0000;
         end else if (sec_wrap) begin
            cyc_reg <= 32'h00000000;
            if (sec_reg >= sec_last) begin
               sec_reg  <= 16'h0000;
               acq_tick <= 1'b1; // [R6]
            end else begin
               sec_reg <= sec_reg + 16'h0001;
            end
         end else begin
            cyc_reg <= cyc_reg + 32'h00000001;
         end
      end
   end

   atipc_irq_pin u_pin_a (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .active     (|to_a),                         // [R15]
      .polarity   (pincfg_reg[`ATIPC_PIN_A_POL]),  // [R7] [R16]
      .open_drain (pincfg_reg[`ATIPC_PIN_A_OD]),   // [R8] [R16]
      .pin_out    (irq_pin_a_out),
      .pin_oe     (irq_pin_a_oe)
   );

   atipc_irq_pin u_pin_b (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .active     (|to_b),                         // [R15]
      .polarity   (pincfg_reg[`ATIPC_PIN_B_POL]),  // [R9] [R16]
      .open_drain (pincfg_reg[`ATIPC_PIN_B_OD]),   // [R10] [R16]
      .pin_out    (irq_pin_b_out),
      .pin_oe     (irq_pin_b_oe)
   );
endmodule // atipc_top
`default_nettype wire

// ### tb/atipc_chk.sv
// Port checker of the alarm target and interrupt pin block.
`default_nettype none
module atipc_chk #(
   parameter int CYCLES_PER_SEC = 10,
   parameter int P_W            = 20,
   parameter int T_W            = 12
) (
   input wire logic           hclk,
   input wire logic           hresetn,
   input wire logic           hsel,
   input wire logic [1:0]     htrans,
   input wire logic           hready,
   input wire logic [31:0]    hrdata,
   input wire logic           hreadyout,
   input wire logic           hresp,
   input wire logic [7:0]     event_flags,
   input wire logic           sample_valid,
   input wire logic [P_W-1:0] alarm_pressure_target,
   input wire logic [T_W-1:0] alarm_temperature_target,
   input wire logic [3:0]     acquisition_period_exponent,
   input wire logic           acq_tick,
   input wire logic           irq_pin_a_out,
   input wire logic           irq_pin_a_oe,
   input wire logic           irq_pin_b_out,
   input wire logic           irq_pin_b_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  xq;
   logic [31:0] cnt;
   logic        ws;
   wire         xfer  = hsel & hready & htrans[1];
   wire         quiet = (xq == 4'h0);
   // A bus access may restart the tick timer, so the next tick is not timed.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xq <= 4'h0;
         cnt <= 32'h0;
         ws <= 1'b1;
      end else begin
         xq <= {xq[2:0], xfer};
         cnt <= acq_tick ? 32'h0 : cnt + 32'h1;
         ws <= xfer | (ws & ~(acq_tick & quiet));
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
   a_ready_high: assert property ($past(hresetn) |-> hreadyout) else $error("wait state");
   a_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("upper data");
   a_tick_pulse: assert property (acq_tick |=> !acq_tick) else $error("long tick");
   a_tick_period: assert property (acq_tick && quiet && !ws
      |-> cnt == (CYCLES_PER_SEC << acquisition_period_exponent) - 1) else $error("period");
   a_exp_quiet: assert property (quiet |-> $stable(acquisition_period_exponent))
      else $error("exponent moved");
   a_tgt_quiet: assert property (quiet && !$past(sample_valid) && !$past(sample_valid, 2)
      |-> $stable({alarm_pressure_target, alarm_temperature_target})) else $error("target");
   a_pin_steady: assert property (quiet && $past(event_flags) == $past(event_flags, 2)
      |-> $stable({irq_pin_a_out, irq_pin_a_oe, irq_pin_b_out, irq_pin_b_oe}))
      else $error("pin moved");
endmodule // atipc_chk
bind atipc_top atipc_chk #(.CYCLES_PER_SEC(CYCLES_PER_SEC), .P_W(P_W), .T_W(T_W)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .event_flags(event_flags),
   .sample_valid(sample_valid), .alarm_pressure_target(alarm_pressure_target),
   .alarm_temperature_target(alarm_temperature_target),
   .acquisition_period_exponent(acquisition_period_exponent), .acq_tick(acq_tick),
   .irq_pin_a_out(irq_pin_a_out), .irq_pin_a_oe(irq_pin_a_oe),
   .irq_pin_b_out(irq_pin_b_out), .irq_pin_b_oe(irq_pin_b_oe));
`default_nettype wire

// ### tb/atipc_host_watch.sv
// Host side of the two interrupt lines, with board pull-ups.
`default_nettype none
module atipc_host_watch (
   input  wire logic a_out,
   input  wire logic a_oe,
   input  wire logic b_out,
   input  wire logic b_oe,
   output wire logic line_a,
   output wire logic line_b
);
   timeunit 1ns;
   timeprecision 1ps;
   // A released line rises to the pull-up level.
   assign line_a = a_oe ? a_out : 1'b1;
   assign line_b = b_oe ? b_out : 1'b1;
endmodule // atipc_host_watch
`default_nettype wire

// ### tb/tb_atipc_top.sv
// Self-checking bench of the alarm target and interrupt pin block.
`default_nettype none
`include "atipc_consts.vh"
module tb_atipc_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CPS = 10;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, sv = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic [7:0]  flags = 8'h00;
   logic [19:0] sp = 20'h0;
   logic [11:0] st = 12'h0;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, tick, irq, ao, ae, bo, be, la, lb;
   wire  [19:0] apt;
   wire  [11:0] att;
   wire  [3:0]  exq;
   int          err_total = 0, n_compared = 0, cyc = 0;
   atipc_top #(.CYCLES_PER_SEC(CPS)) i_atipc_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(`ATIPC_HSIZE_WORD), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .event_flags(flags),
      .sample_valid(sv), .sample_pressure(sp), .sample_temperature(st),
      .alarm_pressure_target(apt), .alarm_temperature_target(att),
      .acquisition_period_exponent(exq), .acq_tick(tick), .irq_pin_a_out(ao),
      .irq_pin_a_oe(ae), .irq_pin_b_out(bo), .irq_pin_b_oe(be), .irq(irq));
   atipc_host_watch i_atipc_host_watch (.a_out(ao), .a_oe(ae), .b_out(bo), .b_oe(be),
      .line_a(la), .line_b(lb));
   initial forever #5 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         summarize();
      end
   end
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      output logic [7:0] r);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= `ATIPC_HTRANS_NSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata[7:0];
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, idx, d, r);
   endtask
   task automatic rc(input logic [7:0] idx, input logic [7:0] e);
      logic [7:0] r;
      bus(1'b0, idx, 8'h00, r);
      chk($sformatf("reg %h", idx), {24'h0, e}, {24'h0, r});
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic cap(input logic [19:0] p, input logic [11:0] t);
      sp <= p;
      st <= t;
      sv <= 1'b1;
      @(posedge hclk);
      sv <= 1'b0;
      tk(2);
   endtask
   function automatic logic lvl(input logic act, input logic pol, input logic od);
      return act ? pol : (od | ~pol);
   endfunction
   initial begin
      int n;
      logic [7:0] c;
      tk(16);
      hresetn <= 1'b1;
      tk(1);
      rc(`ATIPC_IDX_ACQ, 8'h00);
      rc(`ATIPC_IDX_PINCFG, 8'h00);
      rc(`ATIPC_IDX_IEN, 8'h00);
      wr(`ATIPC_IDX_ACQ, 8'hCF);
      rc(`ATIPC_IDX_ACQ, 8'h0F);
      chk("exponent", 32'hF, {28'h0, exq});
      wr(`ATIPC_IDX_PINCFG, 8'hFF);
      rc(`ATIPC_IDX_PINCFG, 8'h33);
      wr(`ATIPC_IDX_IEN, 8'hFF);
      rc(`ATIPC_IDX_IEN, 8'hFF);
      rc(8'h3F, 8'h00);
      wr(`ATIPC_IDX_ROUTE, 8'hAA);
      for (int m = 0; m < 4; m++) begin
         c = {2'h0, m[1], m[0], 2'h0, m[1], m[0]};
         wr(`ATIPC_IDX_PINCFG, c);
         for (int i = 0; i < 9; i++) begin
            flags <= (i < 8) ? 8'h01 << i : 8'h03;
            tk(2);
            chk("pin a", lvl(i == 8 || i % 2 == 1, m[1], m[0]), la);
            chk("pin b", lvl(i % 2 == 0, m[1], m[0]), lb);
         end
      end
      wr(`ATIPC_IDX_IEN, 8'h7F);
      flags <= 8'h80;
      tk(2);
      chk("pin a oe", 32'h0, ae);
      flags <= 8'h00;
      wr(`ATIPC_IDX_IEN, 8'h01);
      wr(`ATIPC_IDX_STATUS, 8'hFF);
      flags <= 8'h03;
      tk(2);
      flags <= 8'h00;
      rc(`ATIPC_IDX_STATUS, 8'h01);
      chk("irq masked", 32'h0, irq);
      wr(`ATIPC_IDX_MASK, 8'h01);
      tk(2);
      chk("irq", 32'h1, irq);
      wr(`ATIPC_IDX_STATUS, 8'h01);
      tk(2);
      chk("irq cleared", 32'h0, irq);
      wr(`ATIPC_IDX_ACQ, 8'h30);
      cap(20'h12345, 12'hABC);
      chk("p tgt", 32'h12345, apt);
      chk("temperature_target", 32'hABC, att);
      cap(20'h54321, 12'h123);
      chk("p tgt hold", 32'h12345, apt);
      wr(`ATIPC_IDX_ACQ, 8'h10);
      wr(`ATIPC_IDX_ACQ, 8'h30);
      cap(20'h54321, 12'h123);
      chk("p tgt new", 32'h54321, apt);
      wr(`ATIPC_IDX_PTGT_HI, 8'h12);
      wr(`ATIPC_IDX_PTGT_LO, 8'h34);
      wr(`ATIPC_IDX_TTGT, 8'h56);
      wr(`ATIPC_IDX_ACQ, 8'h00);
      tk(2);
      chk("p prog", 32'h12340, apt);
      chk("t prog", 32'h560, att);
      wr(`ATIPC_IDX_ACQ, 8'h01);
      n = 0;
      while (tick !== 1'b1) @(posedge hclk);
      do begin
         @(posedge hclk);
         n++;
      end while (tick !== 1'b1);
      chk("tick period", 2 * CPS, n);
      tk(2);
      summarize();
   end
endmodule // tb_atipc_top
`default_nettype wire
